// >>> pirq_pkg.sv
/*
  constants, register map, field positions and carrier types of the prioritized interrupt controller.
  assumes a core that consumes one vector request at a time and a plain register port.
*/
`default_nettype none
package pirq_pkg;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned PC_W           = 21;
  localparam int unsigned PIN_N          = 6;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_PERIPH_EN   = 12'hfa0;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_FLAG = 12'hfa1;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_PRIO = 12'hfa2;
  localparam logic [ADDR_W-1:0] OFS_RESET_CTL   = 12'hff0;
  localparam logic [ADDR_W-1:0] OFS_AUX_CTL     = 12'hff1;
  localparam logic [ADDR_W-1:0] OFS_MAIN_CTL    = 12'hff2;
  // main control fields
  localparam int unsigned MC_GH   = 7;
  localparam int unsigned MC_GL   = 6;
  localparam int unsigned MC_TE   = 5;
  localparam int unsigned MC_XE   = 4;
  localparam int unsigned MC_PE   = 3;
  localparam int unsigned MC_TF   = 2;
  localparam int unsigned MC_XF   = 1;
  localparam int unsigned MC_PF   = 0;
  // aux control fields
  localparam int unsigned AC_PUN  = 7;
  localparam int unsigned AC_EDGE = 6;
  localparam int unsigned AC_TP   = 2;
  localparam int unsigned AC_PP   = 0;
  localparam logic [7:0]  AC_MASK = 8'hc5;
  // peripheral fields and reset-control field
  localparam int unsigned PR_NV   = 4;
  localparam int unsigned PR_LV   = 2;
  localparam logic [7:0]  PR_MASK = 8'h14;
  localparam int unsigned RC_PRIO = 7;
  // reset values
  localparam logic [7:0] MAIN_RST  = 8'h00;
  localparam logic [7:0] AUX_RST   = 8'hc5;
  localparam logic [7:0] PEN_RST   = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] PPRIO_RST = 8'h14;
  localparam logic [7:0] RC_RST    = 8'h00;
  localparam logic [7:0] RD_ZERO   = 8'h00;
  // entry addresses
  localparam logic [PC_W-1:0] HIGH_VEC = 21'h000008;
  localparam logic [PC_W-1:0] LOW_VEC  = 21'h000018;
  // timing
  localparam int unsigned CLK_NS     = 5;
  localparam int unsigned INSTR_NS   = 100;
  localparam int unsigned DIV_CYCLES = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIV_W      = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);
  localparam logic [1:0] LAT_TICKS = 2'h3;

  typedef struct packed {
    logic            timerOverflow;
    logic            nvWriteDone;
    logic            lowVoltage;
  } pirq_events_t;

  typedef struct packed {
    logic [PC_W-1:0] entryAddr;
    logic [PC_W-1:0] pushAddr;
  } pirq_vector_t;
endpackage
`default_nettype wire

// >>> pirq_controller.sv
/*
  prioritized interrupt controller: flag, enable and priority registers, edge and change detection,
  priority or compatibility routing, vector request with stack push, return handling.
  assumes synchronous inputs, one-cycle event pulses, and a core that takes every vector pulse.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - high entry 000008h, low entry 000018h
// - high request preempts running low routine
// - each source has flag, enable; all but edge have priority
// - priority mode only while mode bit set
// - bit7 high enable, bit6 low enable
// - flag, enable, global set vectors at once
// - compatibility ignores priority, single vector
// - accept clears governing global enable
// - accept pushes return, loads entry address
// - return sets governing global enable again
// - pin events vector within three-four cycles
// - flags set regardless of any enable
// - port change flag bit0, sticky
// - timer flag bit2, edge flag bit1, sticky
// - edge select bit6, rising when set
// - pull-up disable bit7, resets to one
// - timer and port priority bits, reset one
// - compatibility peripherals need group enable
// - peripheral priority only in priority mode
// - edge source always high priority
// - nv-done bit4, low-voltage bit2 peripheral
// - mode bit7 of reset control, resets 0
module pirq_controller
  import pirq_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic [pirq_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdata,
  input  wire pirq_pkg::pirq_events_t srcEvents,
  input  wire logic                  extPin,
  input  wire logic [pirq_pkg::PIN_N-1:0] portPins,
  input  wire logic [pirq_pkg::PIN_N-1:0] pullupSel,
  output logic      [pirq_pkg::PIN_N-1:0] pullupEn,
  input  wire logic [pirq_pkg::PC_W-1:0]  returnPc,
  input  wire logic                  returnFromIrq,
  output logic                       vecValid,
  output pirq_pkg::pirq_vector_t     vecOut
);
  import pirq_pkg::*;

  logic [7:0]       main_r, main_nxt;
  logic [7:0]       aux_r;
  logic [7:0]       pen_r;
  logic [7:0]       pflag_r, pflag_nxt;
  logic [7:0]       pprio_r;
  logic [7:0]       rctl_r;
  logic [7:0]       rdata_r;
  logic [DIV_W-1:0] div_r;
  logic [1:0]       lat_r;
  logic             extPrev_r;
  logic [PIN_N-1:0] pinsPrev_r;
  logic             sampValid_r;
  logic             inHigh_r;
  logic             inLow_r;
  logic             vecValid_r;
  pirq_vector_t     vec_r;
  logic [PIN_N-1:0] pullup_r;
  logic             instrTick;
  logic             extEv;
  logic             portEv;
  logic             prioMode;
  logic             actT, actX, actP, actN, actL;
  logic             highReq, lowReq, anyReq;
  logic             accept, acceptHi, acceptLo;
  logic             wrMain, wrPflag;

  assign wrMain   = regWr && (regAddr == OFS_MAIN_CTL);
  assign wrPflag  = regWr && (regAddr == OFS_PERIPH_FLAG);
  assign prioMode = rctl_r[RC_PRIO];

  // instruction-cycle enable derived from the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (div_r == DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign instrTick = (div_r == DIV_LAST);

  // edge and change detection; first sample after reset only primes the history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      extPrev_r   <= 1'b0;
      pinsPrev_r  <= '0;
      sampValid_r <= 1'b0;
    end else begin
      extPrev_r   <= extPin;
      pinsPrev_r  <= portPins;
      sampValid_r <= 1'b1;
    end
  end
  assign extEv  = sampValid_r && (aux_r[AC_EDGE] ? (extPin && !extPrev_r)
                                                 : (!extPin && extPrev_r));
  assign portEv = sampValid_r && (portPins != pinsPrev_r);

  // per-source active terms: flag and enable
  assign actT = main_r[MC_TF] && main_r[MC_TE];
  assign actX = main_r[MC_XF] && main_r[MC_XE];
  assign actP = main_r[MC_PF] && main_r[MC_PE];
  assign actN = pflag_r[PR_NV] && pen_r[PR_NV];
  assign actL = pflag_r[PR_LV] && pen_r[PR_LV];

  // routing: priority mode splits by priority bit, compatibility uses one gate plus group gate
  always_comb begin
    highReq = 1'b0;
    lowReq  = 1'b0;
    if (prioMode) begin
      highReq = main_r[MC_GH] && ((actT && aux_r[AC_TP]) || actX ||
                (actP && aux_r[AC_PP]) || (actN && pprio_r[PR_NV]) ||
                (actL && pprio_r[PR_LV]));
      lowReq  = main_r[MC_GH] && main_r[MC_GL] &&
                ((actT && !aux_r[AC_TP]) || (actP && !aux_r[AC_PP]) ||
                 (actN && !pprio_r[PR_NV]) || (actL && !pprio_r[PR_LV]));
    end else begin
      highReq = main_r[MC_GH] && (actT || actX || actP ||
                (main_r[MC_GL] && (actN || actL)));
    end
  end
  assign anyReq = highReq || lowReq;

  // fixed latency counted in instruction ticks, independent of instruction length
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lat_r <= '0;
    end else if (!anyReq || accept) begin
      lat_r <= '0;
    end else if (instrTick && (lat_r != LAT_TICKS)) begin
      lat_r <= lat_r + 1'b1;
    end
  end
  assign accept   = instrTick && anyReq && (lat_r == LAT_TICKS);
  assign acceptHi = accept && highReq;
  assign acceptLo = accept && !highReq;

  // nesting levels so a return restores the enable of the level it leaves
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inHigh_r <= 1'b0;
      inLow_r  <= 1'b0;
    end else begin
      if (acceptHi && prioMode) begin
        inHigh_r <= 1'b1;
      end else if (returnFromIrq && inHigh_r) begin
        inHigh_r <= 1'b0;
      end
      if (acceptLo) begin
        inLow_r <= 1'b1;
      end else if (returnFromIrq && !inHigh_r && inLow_r) begin
        inLow_r <= 1'b0;
      end
    end
  end

  // main control: write, then return, then accept clear, then event sets win last
  always_comb begin
    main_nxt = main_r;
    if (wrMain) begin
      main_nxt = regWdata;
    end
    if (returnFromIrq) begin
      if (!prioMode || inHigh_r || !inLow_r) begin
        main_nxt[MC_GH] = 1'b1;
      end else begin
        main_nxt[MC_GL] = 1'b1;
      end
    end
    if (acceptHi) begin
      main_nxt[MC_GH] = 1'b0;
    end
    if (acceptLo) begin
      main_nxt[MC_GL] = 1'b0;
    end
    if (srcEvents.timerOverflow) begin
      main_nxt[MC_TF] = 1'b1;
    end
    if (extEv) begin
      main_nxt[MC_XF] = 1'b1;
    end
    if (portEv) begin
      main_nxt[MC_PF] = 1'b1;
    end
  end

  always_comb begin
    pflag_nxt = pflag_r;
    if (wrPflag) begin
      pflag_nxt = regWdata & PR_MASK;
    end
    if (srcEvents.nvWriteDone) begin
      pflag_nxt[PR_NV] = 1'b1;
    end
    if (srcEvents.lowVoltage) begin
      pflag_nxt[PR_LV] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      main_r  <= MAIN_RST;
      pflag_r <= PFLAG_RST;
    end else begin
      main_r  <= main_nxt;
      pflag_r <= pflag_nxt;
    end
  end

  // software-only configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aux_r   <= AUX_RST;
      pen_r   <= PEN_RST;
      pprio_r <= PPRIO_RST;
      rctl_r  <= RC_RST;
    end else if (regWr) begin
      unique case (regAddr)
        OFS_AUX_CTL:     aux_r   <= regWdata & AC_MASK;
        OFS_PERIPH_EN:   pen_r   <= regWdata & PR_MASK;
        OFS_PERIPH_PRIO: pprio_r <= regWdata & PR_MASK;
        OFS_RESET_CTL:   rctl_r  <= {regWdata[RC_PRIO], 7'h00};
        default: ;
      endcase
    end
  end

  // read port answers one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= RD_ZERO;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_MAIN_CTL:    rdata_r <= main_r;
        OFS_AUX_CTL:     rdata_r <= aux_r;
        OFS_PERIPH_EN:   rdata_r <= pen_r;
        OFS_PERIPH_FLAG: rdata_r <= pflag_r;
        OFS_PERIPH_PRIO: rdata_r <= pprio_r;
        OFS_RESET_CTL:   rdata_r <= rctl_r;
        default:         rdata_r <= RD_ZERO;
      endcase
    end
  end
  assign regRdata = rdata_r;

  // vector request: entry address and the return address to push
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vecValid_r <= 1'b0;
      vec_r      <= '0;
    end else begin
      vecValid_r <= accept;
      if (accept) begin
        vec_r.entryAddr <= (prioMode && acceptLo) ? LOW_VEC : HIGH_VEC;
        vec_r.pushAddr  <= returnPc;
      end
    end
  end
  assign vecValid = vecValid_r;
  assign vecOut   = vec_r;

  // pull-ups: global disable (bit set turns all off) over per-pin selection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pullup_r <= '0;
    end else begin
      pullup_r <= aux_r[AC_PUN] ? '0 : pullupSel;
    end
  end
  assign pullupEn = pullup_r;

  // routines are expected to clear flags before re-enabling, else the request re-enters at once

  a_high_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    acceptHi |=> vecValid && vecOut.entryAddr == HIGH_VEC && vecOut.pushAddr == $past(returnPc))
    else $error("high accept did not load high entry");

  a_low_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    acceptLo |-> prioMode && main_r[MC_GH] ##1 vecValid && vecOut.entryAddr == LOW_VEC)
    else $error("low accept wrong entry or gate");

  a_compat_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    (accept && !prioMode) |=> vecOut.entryAddr == HIGH_VEC && !main_r[MC_GH])
    else $error("compatibility accept not single vector");

  a_low_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    acceptLo |=> !main_r[MC_GL] && inLow_r)
    else $error("low accept left low enable set");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcEvents.timerOverflow |=> main_r[MC_TF] ##1 (main_r[MC_TF] || $past(wrMain)))
    else $error("timer flag not held");

  a_edge_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sampValid_r && aux_r[AC_EDGE] && $rose(extPin)) |=> main_r[MC_XF])
    else $error("rising edge not flagged");

  a_ret_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    (returnFromIrq && !prioMode && !accept && !wrMain) |=> main_r[MC_GH])
    else $error("return did not re-enable");

  a_lat_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept |-> $past(lat_r) == LAT_TICKS && instrTick)
    else $error("vector taken outside latency window");

  a_gate_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    (prioMode && !main_r[MC_GH]) |-> !accept)
    else $error("accept with high enable clear");

  a_port_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    portEv |=> main_r[MC_PF])
    else $error("port change not flagged");

  a_edge_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (accept && actX) |-> acceptHi)
    else $error("edge source not taken as high");

  a_compat_group: assert property (@(posedge core_clk) disable iff (!rst_n)
    (accept && !prioMode && !main_r[MC_GL]) |-> (actT || actX || actP))
    else $error("peripheral taken without group enable");

  a_pullup_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    aux_r[AC_PUN] |=> pullupEn == '0)
    else $error("pull-ups on while globally disabled");

  a_ret_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (returnFromIrq && prioMode && !inHigh_r && inLow_r && !acceptLo) |=> main_r[MC_GL])
    else $error("return from low level left low enable clear");

endmodule // pirq_controller
`default_nettype wire

// >>> pirq_core_model.sv
/*
  processor core model for the interrupt controller: takes vector pulses, keeps a return stack,
  issues return pulses on request. assumes pirq_pkg and the controller's vector port.
*/
`timescale 1ns/1ps
`default_nettype none
module pirq_core_model
  import pirq_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    vecValid,
  input  wire pirq_pkg::pirq_vector_t  vecOut,
  input  wire logic                    retReq,
  output logic [pirq_pkg::PC_W-1:0]    returnPc,
  output logic                         returnFromIrq,
  output logic [31:0]                  vecCount,
  output logic [pirq_pkg::PC_W-1:0]    lastEntry,
  output logic                         pushOk
);
  logic [PC_W-1:0] stack_r [31];
  logic [PC_W-1:0] prevPc_r;
  logic [4:0]      sp_r;

  // pc runs every cycle so a push taken from the wrong cycle shows up
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      returnPc      <= '0;
      prevPc_r      <= '0;
      returnFromIrq <= 1'b0;
      vecCount      <= '0;
      lastEntry     <= '0;
      pushOk        <= 1'b1;
      sp_r          <= '0;
    end else begin
      returnFromIrq <= retReq;
      prevPc_r      <= returnPc;
      if (vecValid) begin
        vecCount      <= vecCount + 1;
        lastEntry     <= vecOut.entryAddr;
        returnPc      <= vecOut.entryAddr;
        pushOk        <= pushOk & (vecOut.pushAddr === prevPc_r);
        stack_r[sp_r] <= vecOut.pushAddr;
        sp_r          <= sp_r + 5'h1;
      end else if (returnFromIrq) begin
        returnPc <= stack_r[sp_r - 5'h1];
        sp_r     <= sp_r - 5'h1;
      end else begin
        returnPc <= returnPc + 1'b1;
      end
    end
  end
endmodule // pirq_core_model
`default_nettype wire

// >>> pirq_controller_tb.sv
/*
  testbench for pirq_controller: register tasks, event pulses, vector and latency checks.
  assumes pirq_core_model stands on the vector side.
*/
`timescale 1ns/1ps
`default_nettype none
module pirq_controller_tb;
  import pirq_pkg::*;
  logic                 core_clk, rst_n, regWr, regRd, extPin, retReq, pushOk;
  logic                 returnFromIrq, vecValid;
  logic [ADDR_W-1:0]    regAddr;
  logic [ADDR_W-1:0]    ofs [7];
  logic [7:0]           regWdata, regRdata;
  logic [7:0]           val [7];
  pirq_events_t         srcEvents;
  logic [PIN_N-1:0]     portPins, pullupSel, pullupEn;
  logic [PC_W-1:0]      returnPc, lastEntry;
  pirq_vector_t         vecOut;
  logic [31:0]          vecCount;
  int                   miscompares, checks, lat;

  pirq_controller dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcEvents(srcEvents), .extPin(extPin),
    .portPins(portPins), .pullupSel(pullupSel), .pullupEn(pullupEn), .returnPc(returnPc),
    .returnFromIrq(returnFromIrq), .vecValid(vecValid), .vecOut(vecOut));
  pirq_core_model core (.core_clk(core_clk), .rst_n(rst_n), .vecValid(vecValid), .vecOut(vecOut),
    .retReq(retReq), .returnPc(returnPc), .returnFromIrq(returnFromIrq), .vecCount(vecCount),
    .lastEntry(lastEntry), .pushOk(pushOk));

  task automatic chk(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk("register read", {13'h0, exp}, {13'h0, regRdata});
  endtask
  task automatic ev(input pirq_events_t e);
    @(posedge core_clk);
    srcEvents <= e;
    @(posedge core_clk);
    srcEvents <= '0;
  endtask
  task automatic ret();
    @(posedge core_clk);
    retReq <= 1'b1;
    @(posedge core_clk);
    retReq <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // bounded wait: a late or missing vector counts as a mismatch
  task automatic waitVec(input logic [PC_W-1:0] exp);
    logic [31:0] c0;
    c0  = vecCount;
    lat = 0;
    while (vecCount === c0 && lat < 150) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    chk("vector taken", PC_W'(1), PC_W'(lat < 150));
    chk("entry address", exp, lastEntry);
    chk("pushed return", PC_W'(1), PC_W'(pushOk));
  endtask
  task automatic noVec(input int n);
    logic [31:0] c0;
    c0 = vecCount;
    repeat (n) @(posedge core_clk);
    chk("vector count", c0[PC_W-1:0], vecCount[PC_W-1:0]);
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = '0; regWdata = '0; srcEvents = '0;
    extPin = 1'b0; portPins = '0; pullupSel = 6'h2d; retReq = 1'b0; miscompares = 0; checks = 0;
    ofs = '{OFS_MAIN_CTL, OFS_AUX_CTL, OFS_RESET_CTL, OFS_PERIPH_EN, OFS_PERIPH_FLAG, OFS_PERIPH_PRIO, 12'h000};
    val = '{8'h00, 8'hc5, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rdchk(ofs[i], val[i]);
    wr(OFS_RESET_CTL, 8'hff);
    rdchk(OFS_RESET_CTL, 8'h80);
    wr(OFS_RESET_CTL, 8'h00);
    chk("pullups", '0, PC_W'(pullupEn));
    wr(OFS_AUX_CTL, 8'h45);
    repeat (2) @(posedge core_clk);
    chk("pullups", PC_W'(pullupSel), PC_W'(pullupEn));
    wr(OFS_AUX_CTL, 8'hc5);
    // flags with every enable off
    ev(3'b100);
    @(posedge core_clk);
    portPins <= 6'h08;
    extPin   <= 1'b1;
    repeat (3) @(posedge core_clk);
    extPin <= 1'b0;
    rdchk(OFS_MAIN_CTL, 8'h07);
    wr(OFS_MAIN_CTL, 8'h00);
    rdchk(OFS_MAIN_CTL, 8'h00);
    wr(OFS_AUX_CTL, 8'h85);
    wr(OFS_MAIN_CTL, 8'h00);
    @(posedge core_clk);
    extPin <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(OFS_MAIN_CTL, 8'h00);
    extPin <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(OFS_MAIN_CTL, 8'h02);
    wr(OFS_AUX_CTL, 8'hc1);
    wr(OFS_MAIN_CTL, 8'h00);
    // compatibility mode, timer marked low yet still on the single vector
    wr(OFS_MAIN_CTL, 8'ha0);
    ev(3'b100);
    waitVec(HIGH_VEC);
    rdchk(OFS_MAIN_CTL, 8'h24);
    wr(OFS_MAIN_CTL, 8'h20);
    ret();
    rdchk(OFS_MAIN_CTL, 8'ha0);
    wr(OFS_PERIPH_EN, 8'h10);
    wr(OFS_MAIN_CTL, 8'h80);
    ev(3'b010);
    noVec(130);
    wr(OFS_MAIN_CTL, 8'hc0);
    waitVec(HIGH_VEC);
    rdchk(OFS_PERIPH_FLAG, 8'h10);
    wr(OFS_PERIPH_FLAG, 8'h00);
    wr(OFS_PERIPH_EN, 8'h00);
    wr(OFS_MAIN_CTL, 8'h00);
    // priority mode
    wr(OFS_RESET_CTL, 8'h80);
    wr(OFS_MAIN_CTL, 8'h60);
    ev(3'b100);
    noVec(130);
    wr(OFS_MAIN_CTL, 8'he4);
    waitVec(LOW_VEC);
    rdchk(OFS_MAIN_CTL, 8'ha4);
    wr(OFS_MAIN_CTL, 8'hb0);
    @(posedge core_clk);
    extPin <= 1'b1;
    waitVec(HIGH_VEC);
    chk("edge latency", PC_W'(1), PC_W'(lat inside {[60:90]}));
    rdchk(OFS_MAIN_CTL, 8'h32);
    wr(OFS_MAIN_CTL, 8'h30);
    ret();
    rdchk(OFS_MAIN_CTL, 8'hb0);
    ret();
    rdchk(OFS_MAIN_CTL, 8'hf0);
    wr(OFS_MAIN_CTL, 8'h00);
    wr(OFS_PERIPH_PRIO, 8'h10);
    wr(OFS_PERIPH_EN, 8'h04);
    wr(OFS_MAIN_CTL, 8'hc0);
    ev(3'b001);
    waitVec(LOW_VEC);
    final_report();
  end
endmodule // pirq_controller_tb
`default_nettype wire
